// *** hdl/rmc_pkg.sv ***
// Purpose: shared constants and types for the radio control ends
// Assumes: 10 MHz core clock on both ends
// Notes:   long counts are defaults of top-level parameters

package rmc_pkg;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_HZ       = 10_000_000;
	localparam int CYC_PER_MS   = CLK_HZ / 1000;
	localparam int INIT1_MS     = 5;
	localparam int INIT2_MS     = 500;
	localparam int SWITCH_MS    = 40;
	localparam int HOST_WAIT_MS = 2;
	localparam int CNT_W        = 24;

	function automatic int ms_to_cyc(input int ms);
		ms_to_cyc = (ms * CYC_PER_MS < 1) ? 1 : ms * CYC_PER_MS;
	endfunction

	localparam int INIT1_CYC     = ms_to_cyc(INIT1_MS);
	localparam int INIT2_CYC     = ms_to_cyc(INIT2_MS);
	localparam int SWITCH_CYC    = ms_to_cyc(SWITCH_MS);
	localparam int HOST_WAIT_CYC = ms_to_cyc(HOST_WAIT_MS);
	localparam int RST_PULSE_CYC = 16;
	localparam int IDLE_CYC      = 1000;

	// ****************************************************
	// Buffer and addressing
	// ****************************************************
	localparam int          BUF_DEPTH  = 4096;
	localparam int          BUF_AW     = 12;
	localparam int          PKT_BYTES  = 55;
	localparam logic [15:0] ADDR_BCAST = 16'hffff;
	localparam logic [2:0]  SYNC_RST   = 3'h0;

	// ****************************************************
	// Modes and states
	// ****************************************************
	typedef enum logic [1:0] {
		MODE_STREAM  = 2'b00,
		MODE_GENERAL = 2'b01,
		MODE_CONFIG  = 2'b10,
		MODE_SLEEP   = 2'b11
	} rmc_mode_t;

	typedef enum logic [1:0] {
		DS_INIT1  = 2'b00,
		DS_INIT2  = 2'b01,
		DS_RUN    = 2'b10,
		DS_SWITCH = 2'b11
	} rmc_dev_state_t;

	typedef enum logic [2:0] {
		HS_RESET     = 3'b000,
		HS_WAIT_LOW  = 3'b001,
		HS_WAIT_HIGH = 3'b010,
		HS_SETTLE    = 3'b011,
		HS_READY     = 3'b100
	} rmc_host_state_t;

endpackage

// *** hdl/rmc_if.sv ***
// Purpose: control pins between host controller and radio module
// Assumes: all pins are plain single-driver levels
// Notes:   status_idle high means module idle and operational

interface rmc_if;
	logic module_reset_in_n;
	logic mode_select_low;
	logic mode_select_high;
	logic status_idle;

	modport dev (
		input  module_reset_in_n,
		input  mode_select_low,
		input  mode_select_high,
		output status_idle
	);

	modport host (
		output module_reset_in_n,
		output mode_select_low,
		output mode_select_high,
		input  status_idle
	);
endinterface

// *** hdl/rmc_dev.sv ***
// Purpose: radio module control end: status line, modes, tx buffer
// Assumes: host keeps its own duties; pins arrive asynchronously
// Notes:   radio modem and serial framing live outside this block
//
// What this block does
// - low reset pin resets the module
// - two mode pins pick four modes
// - decode 00 stream, 01 general, 10 config, 11 sleep
// - all-ones own address transmits as broadcast
// - all-ones own address accepts every destination
// - status low at power-up during self-test
// - status rises after self-test, mode from pins
// - host waits for status rising edge
// - status low while tx, rx or init busy
// - status low during serial output of data
// - 4096-byte buffer takes bursts while status high
// - general mode status low while buffer holds data
// - streaming mode passes data straight through
// - status high does not mean air done
// - self-test only after power, pin or command reset, wake
// - init phases 5 ms then 500 ms
// - mode change: status low, switch, status high
// - any busy condition forces status low
// - no mode evaluation while status low
// - host waits 2 ms after status rises
// - leaving sleep or reset reloads parameters

module rmc_dev
	import rmc_pkg::*;
#(
	parameter int P_INIT1_CYC  = INIT1_CYC,
	parameter int P_INIT2_CYC  = INIT2_CYC,
	parameter int P_SWITCH_CYC = SWITCH_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	rmc_if.dev               pins,
	input  wire logic        i_cmd_reset,
	input  wire logic [15:0] i_own_addr,
	input  wire logic        i_ser_valid,
	input  wire logic [7:0]  i_ser_data,
	output logic             o_ser_ready,
	output logic             o_air_valid,
	output logic [7:0]       o_air_data,
	input  wire logic        i_air_ready,
	output logic             o_tx_broadcast,
	input  wire logic        i_air_rx_valid,
	input  wire logic [15:0] i_air_rx_dest,
	output logic             o_rx_accept,
	input  wire logic        i_rx_pending,
	output rmc_mode_t        o_mode
);

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		rmc_dev_state_t    st;
		logic [CNT_W-1:0]  cnt;
		rmc_mode_t         mode;
		logic [2:0]        rst_sy;
		logic [2:0]        mlo_sy;
		logic [2:0]        mhi_sy;
		logic              rst_pin_n;
		logic [1:0]        pin_mode;
		logic [BUF_AW:0]   wr;
		logic [BUF_AW:0]   rd;
		logic [15:0]       idle;
		logic              out_v;
		logic [7:0]        out_d;
		logic              aux;
		logic              rx_acc;
		logic              bcast;
	} rmc_dev_st_t;

	localparam rmc_dev_st_t ST_RST = '{
		st: DS_INIT1, mode: MODE_STREAM, default: '0};

	rmc_dev_st_t     st_reg;
	rmc_dev_st_t     st_next;
	logic [7:0]      mem [BUF_DEPTH];
	logic [BUF_AW:0] fill;
	logic            wr_en;
	logic            rd_en;
	logic            tx_go;
	logic            data_busy;

	function automatic logic cnt_done(input logic [CNT_W-1:0] c,
			input int lim);
		cnt_done = (c >= CNT_W'(lim - 1));
	endfunction

	function automatic logic addr_match(input logic [15:0] own,
			input logic [15:0] dest);
		addr_match = (own == ADDR_BCAST) || (own == dest);
	endfunction

	// ****************************************************
	// Buffer handshakes
	// ****************************************************
	assign fill = st_reg.wr - st_reg.rd;

	// Serial input only in the two transfer modes, and never past full
	assign o_ser_ready = (st_reg.st == DS_RUN)
		&& (st_reg.mode == MODE_STREAM || st_reg.mode == MODE_GENERAL)
		&& (fill != (BUF_AW+1)'(BUF_DEPTH));
	assign wr_en = i_ser_valid && o_ser_ready;

	// General mode waits for a full packet or an input lull
	assign tx_go = (st_reg.mode == MODE_STREAM)
		|| (fill >= (BUF_AW+1)'(PKT_BYTES))
		|| (st_reg.idle >= 16'(IDLE_CYC));
	assign rd_en = (fill != '0) && tx_go
		&& (!st_reg.out_v || i_air_ready);

	assign data_busy = (fill != '0) || st_reg.out_v || i_rx_pending;

	always_ff @(posedge i_core_clk) begin
		if (wr_en) begin
			mem[st_reg.wr[BUF_AW-1:0]] <= i_ser_data;
		end
	end

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		st_next = st_reg;

		// Second and third stages must agree before a level counts
		st_next.rst_sy = {st_reg.rst_sy[1:0], pins.module_reset_in_n};
		st_next.mlo_sy = {st_reg.mlo_sy[1:0], pins.mode_select_low};
		st_next.mhi_sy = {st_reg.mhi_sy[1:0], pins.mode_select_high};
		if (st_reg.rst_sy[2] == st_reg.rst_sy[1]) begin
			st_next.rst_pin_n = st_reg.rst_sy[2];
		end
		if (st_reg.mlo_sy[2] == st_reg.mlo_sy[1]) begin
			st_next.pin_mode[0] = st_reg.mlo_sy[2];
		end
		if (st_reg.mhi_sy[2] == st_reg.mhi_sy[1]) begin
			st_next.pin_mode[1] = st_reg.mhi_sy[2];
		end

		if (wr_en) begin
			st_next.wr = st_reg.wr + 1'b1;
			st_next.idle = '0;
		end else if (fill != '0 && st_reg.idle != 16'hffff) begin
			st_next.idle = st_reg.idle + 1'b1;
		end

		if (!st_reg.out_v || i_air_ready) begin
			st_next.out_v = 1'b0;
		end
		if (rd_en) begin
			st_next.out_v = 1'b1;
			st_next.out_d = mem[st_reg.rd[BUF_AW-1:0]];
			st_next.rd = st_reg.rd + 1'b1;
		end

		case (st_reg.st)
			DS_INIT1: begin
				st_next.cnt = st_reg.cnt + 1'b1;
				if (cnt_done(st_reg.cnt, P_INIT1_CYC)) begin
					st_next.st = DS_INIT2;
					st_next.cnt = '0;
				end
			end
			DS_INIT2: begin
				// Parameter reload; mode taken from pins at the end
				st_next.cnt = st_reg.cnt + 1'b1;
				if (cnt_done(st_reg.cnt, P_INIT2_CYC)) begin
					st_next.st = DS_RUN;
					st_next.cnt = '0;
					st_next.mode = rmc_mode_t'(st_reg.pin_mode);
				end
			end
			DS_RUN: begin
				// Pins looked at only while the status line is high
				if (st_reg.aux && !data_busy
						&& st_reg.pin_mode != st_reg.mode) begin
					st_next.st = DS_SWITCH;
					st_next.cnt = '0;
				end
			end
			DS_SWITCH: begin
				st_next.cnt = st_reg.cnt + 1'b1;
				if (cnt_done(st_reg.cnt, P_SWITCH_CYC)) begin
					st_next.cnt = '0;
					st_next.mode = rmc_mode_t'(st_reg.pin_mode);
					// Wake from sleep redoes the whole self-test
					if (st_reg.mode == MODE_SLEEP
							&& st_reg.pin_mode != MODE_SLEEP) begin
						st_next.st = DS_INIT1;
					end else begin
						st_next.st = DS_RUN;
					end
				end
			end
			default: begin
				st_next.st = DS_INIT1;
				st_next.cnt = '0;
			end
		endcase

		// Pin or command reset restarts self-test and drops buffered data
		if (!st_reg.rst_pin_n || i_cmd_reset) begin
			st_next.st = DS_INIT1;
			st_next.cnt = '0;
			st_next.wr = '0;
			st_next.rd = '0;
			st_next.out_v = 1'b0;
			st_next.idle = '0;
		end

		// Low wins: any busy source pulls the line down
		st_next.aux = (st_reg.st == DS_RUN)
			&& (st_next.st == DS_RUN)
			&& !data_busy && !wr_en;

		st_next.bcast = (i_own_addr == ADDR_BCAST);
		st_next.rx_acc = i_air_rx_valid && (st_reg.st == DS_RUN)
			&& (st_reg.mode == MODE_STREAM
				|| st_reg.mode == MODE_GENERAL)
			&& addr_match(i_own_addr, i_air_rx_dest);
	end

	// ****************************************************
	// Registers
	// ****************************************************
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign pins.status_idle = st_reg.aux;
	assign o_air_valid     = st_reg.out_v;
	assign o_air_data      = st_reg.out_d;
	assign o_tx_broadcast  = st_reg.bcast;
	assign o_rx_accept     = st_reg.rx_acc;
	assign o_mode          = st_reg.mode;

endmodule

// *** hdl/rmc_host.sv ***
// Purpose: host controller end: drives reset and mode pins
// Assumes: module status line arrives asynchronously
// Notes:   o_ready only means control idle, not air transfer done

module rmc_host
	import rmc_pkg::*;
#(
	parameter int P_WAIT_CYC = HOST_WAIT_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_reset,
	rmc_if.host             pins,
	input  wire logic       i_reset_req,
	input  wire rmc_mode_t  i_mode,
	output logic            o_ready,
	output rmc_host_state_t o_state
);

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		rmc_host_state_t  st;
		logic [CNT_W-1:0] cnt;
		logic [2:0]       aux_sy;
		logic             aux;
		logic [1:0]       mode_out;
		logic             rst_n_out;
	} rmc_host_st_t;

	localparam rmc_host_st_t ST_RST = '{st: HS_RESET, default: '0};

	rmc_host_st_t st_reg;
	rmc_host_st_t st_next;

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		st_next = st_reg;
		st_next.aux_sy = {st_reg.aux_sy[1:0], pins.status_idle};
		if (st_reg.aux_sy[2] == st_reg.aux_sy[1]) begin
			st_next.aux = st_reg.aux_sy[2];
		end

		case (st_reg.st)
			HS_RESET: begin
				// Pins held driven from the start, never left to pull-ups
				st_next.rst_n_out = 1'b0;
				st_next.mode_out = i_mode;
				st_next.cnt = st_reg.cnt + 1'b1;
				if (st_reg.cnt >= CNT_W'(RST_PULSE_CYC - 1)) begin
					st_next.rst_n_out = 1'b1;
					st_next.cnt = '0;
					st_next.st = HS_WAIT_LOW;
				end
			end
			HS_WAIT_LOW: begin
				if (!st_reg.aux) begin
					st_next.st = HS_WAIT_HIGH;
				end
			end
			HS_WAIT_HIGH: begin
				// Rising edge marks the module as operational
				if (st_reg.aux) begin
					st_next.st = HS_SETTLE;
					st_next.cnt = '0;
				end
			end
			HS_SETTLE: begin
				// Extra margin costs 2 ms on power-up too, kept simple
				st_next.cnt = st_reg.cnt + 1'b1;
				if (st_reg.cnt >= CNT_W'(P_WAIT_CYC - 1)) begin
					st_next.st = HS_READY;
					st_next.cnt = '0;
				end
			end
			HS_READY: begin
				if (i_mode != rmc_mode_t'(st_reg.mode_out)) begin
					st_next.mode_out = i_mode;
					st_next.st = HS_WAIT_LOW;
				end
				if (!st_reg.aux) begin
					st_next.st = HS_WAIT_HIGH;
				end
			end
			default: begin
				st_next.st = HS_RESET;
				st_next.cnt = '0;
			end
		endcase

		if (i_reset_req) begin
			st_next.st = HS_RESET;
			st_next.cnt = '0;
			st_next.rst_n_out = 1'b0;
		end
	end

	// ****************************************************
	// Registers
	// ****************************************************
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign pins.module_reset_in_n = st_reg.rst_n_out;
	assign pins.mode_select_low   = st_reg.mode_out[0];
	assign pins.mode_select_high  = st_reg.mode_out[1];
	// Ready does not promise the last packet has left the air
	assign o_ready = (st_reg.st == HS_READY);
	assign o_state = st_reg.st;

endmodule

// *** sim/rmc_properties.sv ***
// Purpose: pin timing checks beside the control interface
// Assumes: one clock, synchronous active-high reset
// Notes:   windows sized for the shortened bench counts

module rmc_properties
	import rmc_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_reset,
	input wire logic        module_reset_in_n,
	input wire logic        mode_select_low,
	input wire logic        mode_select_high,
	input wire logic        status_idle,
	input wire logic [15:0] i_own_addr,
	input wire logic        i_ser_valid,
	input wire logic        o_ser_ready,
	input wire logic        i_air_rx_valid,
	input wire logic [15:0] i_air_rx_dest,
	input wire logic        o_rx_accept,
	input wire logic        i_rx_pending,
	input wire logic        o_tx_broadcast,
	input wire rmc_mode_t   o_mode
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] pin_mode;
	assign pin_mode = {mode_select_high, mode_select_low};

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence s_pin_change;
		status_idle && $changed(pin_mode);
	endsequence
	// One-cycle high before a deferred switch is no finished switch
	sequence s_switch_done;
		$rose(status_idle) ##1 status_idle;
	endsequence

	// Pin synchroniser needs a few edges before status drops
	AST_RESET_LOW: assert property (
		!module_reset_in_n [*7] |-> !status_idle)
		else $error("status high while reset pin held");
	AST_INIT_LOW: assert property (
		$rose(module_reset_in_n) |-> !status_idle [*8])
		else $error("status high during init");
	AST_PEND_BUSY: assert property (
		i_rx_pending |=> !status_idle)
		else $error("status high during serial output");
	AST_WRITE_BUSY: assert property (
		i_ser_valid && o_ser_ready |=> !status_idle)
		else $error("status high after buffered write");
	AST_RX_FILTER: assert property (
		i_air_rx_valid && i_own_addr != 16'hffff
		&& i_air_rx_dest != i_own_addr |=> !o_rx_accept)
		else $error("foreign packet accepted");
	AST_BCAST: assert property (
		!$past(i_reset) |->
		o_tx_broadcast == $past(i_own_addr == 16'hffff))
		else $error("broadcast flag wrong");
	AST_SWITCH_LOW: assert property (
		s_pin_change |-> ##[1:10] !status_idle)
		else $error("no busy phase after mode change");
	AST_MODE_FOLLOW: assert property (
		s_switch_done |-> o_mode == pin_mode)
		else $error("mode differs from pins when idle");
	AST_HOST_SETTLE: assert property (
		s_switch_done |=> $stable(pin_mode) [*8])
		else $error("host moved pins too soon");
endmodule

// *** sim/test_radio_module_aux_mode_control.sv ***
// Purpose: both control ends joined, driven from user sides
// Assumes: shortened init, switch and settle counts
// Notes:   air side stalls until the first byte is checked

module test_radio_module_aux_mode_control
	import rmc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic            clk, rst, cmd_rst, reset_req, ser_valid, air_ready;
	logic            rx_valid, rx_pend, ser_ready, air_valid, tx_bcast;
	logic            rx_acc, ready;
	logic [15:0]     own, dest;
	logic [7:0]      ser_data, air_data;
	rmc_mode_t       mode_want, mode;
	rmc_host_state_t hstate;
	int              mismatches, num_checks, cycles;
	rmc_mode_t       seq_m[3] = '{MODE_CONFIG, MODE_SLEEP, MODE_STREAM};
	logic [15:0]     tab[3][3] = '{'{16'h1234, 16'h1234, 16'h1},
		'{16'h1234, 16'h4321, 16'h0}, '{16'hffff, 16'h4321, 16'h1}};

	rmc_if u_rmc_if ();
	rmc_dev #(.P_INIT1_CYC(20), .P_INIT2_CYC(40), .P_SWITCH_CYC(30)) u_rmc_dev (
		.i_core_clk(clk), .i_reset(rst), .pins(u_rmc_if.dev),
		.i_cmd_reset(cmd_rst), .i_own_addr(own), .i_ser_valid(ser_valid),
		.i_ser_data(ser_data), .o_ser_ready(ser_ready),
		.o_air_valid(air_valid), .o_air_data(air_data),
		.i_air_ready(air_ready), .o_tx_broadcast(tx_bcast),
		.i_air_rx_valid(rx_valid), .i_air_rx_dest(dest),
		.o_rx_accept(rx_acc), .i_rx_pending(rx_pend), .o_mode(mode));
	rmc_host #(.P_WAIT_CYC(10)) u_rmc_host (
		.i_core_clk(clk), .i_reset(rst), .pins(u_rmc_if.host),
		.i_reset_req(reset_req), .i_mode(mode_want), .o_ready(ready),
		.o_state(hstate));
	rmc_properties u_rmc_properties (
		.i_core_clk(clk), .i_reset(rst),
		.module_reset_in_n(u_rmc_if.module_reset_in_n),
		.mode_select_low(u_rmc_if.mode_select_low),
		.mode_select_high(u_rmc_if.mode_select_high),
		.status_idle(u_rmc_if.status_idle), .i_own_addr(own),
		.i_ser_valid(ser_valid), .o_ser_ready(ser_ready),
		.i_air_rx_valid(rx_valid), .i_air_rx_dest(dest),
		.o_rx_accept(rx_acc), .i_rx_pending(rx_pend),
		.o_tx_broadcast(tx_bcast), .o_mode(mode));

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	// ****************************************************
	// Access tasks
	// ****************************************************
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#5;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 3000) begin
			tick();
			n++;
		end
		chk(16'(ready), 16'h1);
	endtask

	// Air side is watched directly; status alone says nothing of it
	task automatic wait_air;
		int n;
		n = 0;
		while (air_valid !== 1'b1 && n < 1200) begin
			tick();
			n++;
		end
	endtask

	// Host needs a few edges to notice the busy phase
	task automatic settle;
		tick(12);
		wait_ready();
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			report_and_stop();
		end
	end

	initial begin
		{rst, cmd_rst, reset_req, ser_valid, air_ready} = 5'h10;
		{rx_valid, rx_pend, ser_data, dest} = '0;
		own = 16'h1234;
		mode_want = MODE_STREAM;
		tick(6);
		rst = 0;
		chk(16'(u_rmc_if.status_idle), 16'h0);
		tick(2);
		chk(16'(u_rmc_if.module_reset_in_n), 16'h0);
		wait_ready();
		chk(16'(mode), 16'(MODE_STREAM));
		ser_data = 8'h5a;
		ser_valid = 1;
		tick();
		ser_valid = 0;
		chk(16'(u_rmc_if.status_idle), 16'h0);
		tick(4);
		chk({air_valid, air_data}, 16'h15a);
		air_ready = 1;
		settle();
		for (int i = 0; i < 3; i++) begin
			own = tab[i][0];
			dest = tab[i][1];
			tick();
			rx_valid = 1;
			tick();
			rx_valid = 0;
			chk(16'(rx_acc), tab[i][2]);
			chk(16'(tx_bcast), 16'(own == 16'hffff));
		end
		own = 16'h1234;
		rx_pend = 1;
		tick(2);
		chk(16'(u_rmc_if.status_idle), 16'h0);
		mode_want = MODE_GENERAL;
		tick(40);
		chk(16'(mode), 16'(MODE_STREAM));
		chk(16'(hstate), 16'(HS_WAIT_HIGH));
		rx_pend = 0;
		wait_ready();
		settle();
		chk(16'(mode), 16'(MODE_GENERAL));
		// General mode holds bytes until the input lull times out
		air_ready = 0;
		ser_valid = 1;
		ser_data = 8'h11;
		tick();
		chk(16'(ser_ready), 16'h1);
		ser_data = 8'h22;
		tick();
		ser_data = 8'h33;
		tick();
		ser_valid = 0;
		tick(100);
		chk(16'({air_valid, u_rmc_if.status_idle}), 16'h0);
		wait_air();
		chk({air_valid, air_data}, 16'h111);
		air_ready = 1;
		tick();
		chk({air_valid, air_data}, 16'h122);
		tick();
		chk({air_valid, air_data}, 16'h133);
		settle();
		foreach (seq_m[i]) begin
			mode_want = seq_m[i];
			settle();
			chk(16'(mode), 16'(seq_m[i]));
			chk(16'({u_rmc_if.mode_select_high,
				u_rmc_if.mode_select_low}), 16'(seq_m[i]));
			chk(16'(ser_ready), 16'(!seq_m[i][1]));
		end
		cmd_rst = 1;
		tick();
		cmd_rst = 0;
		tick();
		chk(16'(u_rmc_if.status_idle), 16'h0);
		settle();
		reset_req = 1;
		tick();
		reset_req = 0;
		tick(2);
		chk(16'(u_rmc_if.module_reset_in_n), 16'h0);
		settle();
		chk(16'(u_rmc_if.status_idle), 16'h1);
		report_and_stop();
	end
endmodule
